/* File: logic/amf_pkg.sv */
// constants for the alarm mask and lane fault flag block
// What this block does
// - mask bit 5 set keeps lane-buffer fault out of summary alarm; resets one.
// - mask bit 4 set keeps serializer pll fault out of summary alarm; resets one.
// - mask bit 3 set keeps link-state fault out of summary alarm; resets one.
// - mask bit 2 set keeps clock realign fault out of summary alarm; resets one.
// - mask bit 0 set keeps divider mismatch fault out of summary alarm; resets one.
// - lane i buffer overflow or underflow sets per-lane fault bit i.
// - writing one clears a per-lane fault bit; persisting fault sets it again.
// - writing one to aggregate lane-buffer status bit clears all per-lane bits.
// - per-lane fault bits all read one after reset.
// - summary alarm is one when any unmasked status bit other than bit 1 is set.
// - aggregate lane-buffer status sets on any lane fault; write one clears.
// - every alarm status bit is one after power-on or soft reset.
package amf_pkg;
    localparam logic [11:0] ADDR_SUMMARY  = 12'h02c0;
    localparam logic [11:0] ADDR_STATUS   = 12'h02c1;
    localparam logic [11:0] ADDR_MASK     = 12'h02c2;
    localparam logic [11:0] ADDR_LANE     = 12'h02c4;
    localparam logic [11:0] ADDR_SOFT_RST = 12'h02c8;
    localparam logic [11:0] ADDR_INT_MASK = 12'h02cc;
    localparam logic [11:0] ADDR_INT_STAT = 12'h02d0;
    localparam int BIT_LANE    = 5;
    localparam int BIT_PLL     = 4;
    localparam int BIT_LINK    = 3;
    localparam int BIT_REALIGN = 2;
    localparam int BIT_DIVIDER = 0;
    localparam logic [7:0] STATUS_IMPL  = 8'h3d;
    localparam logic [7:0] STATUS_RESET = 8'h3f;
    localparam logic [7:0] MASK_RESET   = 8'h3f;
    localparam logic [7:0] LANE_RESET   = 8'hff;
    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;
endpackage

/* File: logic/amf_alarm_top.sv */
// alarm mask, status and per-lane fault flag registers on axi4-lite
`timescale 1ns/100ps
module amf_alarm_top #(
    parameter int LANES = 8
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [7:0]  lane_fault_i,
    input  wire logic        pll_unlocked_i,
    input  wire logic        link_not_ready_i,
    input  wire logic        clock_realigned_i,
    input  wire logic        divider_mismatch_i,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             summary_alarm_o,
    output logic             irq_o
);
    import amf_pkg::*;

    if (LANES != 8) begin
        $error("LANES must be 8");
    end

    // ****************************************
    // write and read channels
    // ****************************************
    logic        aw_held_r, aw_held_nxt;
    logic        w_held_r, w_held_nxt;
    logic [11:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic        w_lane0_r, w_lane0_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wr_fire;
    logic        aw_have;
    logic        w_have;
    logic        rd_fire;
    logic [7:0]  wbyte;

    // ****************************************
    // alarm state
    // ****************************************
    logic [7:0] status_r, status_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] lane_r, lane_nxt;
    logic [2:0] int_stat_r, int_stat_nxt;
    logic [2:0] int_mask_r, int_mask_nxt;
    logic [7:0] events;
    logic       summary;
    logic       soft_rst;
    logic       alarm_q_r;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    assign aw_have = aw_held_r || (s_axi_awvalid && s_axi_awready);
    assign w_have  = w_held_r || (s_axi_wvalid && s_axi_wready);
    assign wr_fire = aw_have && w_have && !bvalid_r;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wbyte   = w_data_nxt[7:0];

    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_lane0_nxt = w_lane0_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt  = 1'b1;
            w_data_nxt  = s_axi_wdata;
            w_lane0_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            case (aw_addr_nxt)
                ADDR_SUMMARY, ADDR_STATUS, ADDR_MASK, ADDR_LANE,
                ADDR_SOFT_RST, ADDR_INT_MASK, ADDR_INT_STAT: bresp_nxt = RESP_OKAY;
                default: bresp_nxt = RESP_SLVERR;
            endcase
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (rd_fire) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_SUMMARY:  rdata_nxt = {31'h0000_0000, summary};
                ADDR_STATUS:   rdata_nxt = {24'h00_0000, status_r};
                ADDR_MASK:     rdata_nxt = {24'h00_0000, mask_r};
                ADDR_LANE:     rdata_nxt = {24'h00_0000, lane_r};
                ADDR_SOFT_RST: rdata_nxt = 32'h0000_0000;
                ADDR_INT_MASK: rdata_nxt = {29'h0000_0000, int_mask_r};
                ADDR_INT_STAT: rdata_nxt = {29'h0000_0000, int_stat_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    // ****************************************
    // status, mask and lane flags
    // ****************************************
    assign events = {2'b00, |lane_fault_i, pll_unlocked_i, link_not_ready_i,
                     clock_realigned_i, 1'b0, divider_mismatch_i};
    assign soft_rst = wr_fire && aw_addr_nxt == ADDR_SOFT_RST && w_lane0_nxt && wbyte[0];
    assign summary = |(status_r & ~mask_r & STATUS_IMPL);
    assign summary_alarm_o = summary;

    always_comb begin
        status_nxt   = status_r;
        mask_nxt     = mask_r;
        lane_nxt     = lane_r;
        int_mask_nxt = int_mask_r;
        int_stat_nxt = int_stat_r;
        if (wr_fire && w_lane0_nxt) begin
            case (aw_addr_nxt)
                ADDR_STATUS: begin
                    status_nxt = status_r & ~(wbyte & STATUS_IMPL);
                    if (wbyte[BIT_LANE]) begin
                        lane_nxt = 8'h00;
                    end
                end
                ADDR_MASK:     mask_nxt = wbyte;
                ADDR_LANE:     lane_nxt = lane_r & ~wbyte;
                ADDR_INT_MASK: int_mask_nxt = wbyte[2:0];
                default:       status_nxt = status_nxt;
            endcase
        end
        if (rd_fire && s_axi_araddr == ADDR_INT_STAT) begin
            int_stat_nxt = 3'b000;
        end
        // events win over clears
        status_nxt = status_nxt | events;
        lane_nxt   = lane_nxt | lane_fault_i;
        int_stat_nxt = int_stat_nxt | {|lane_fault_i, summary && !alarm_q_r, |events};
        if (soft_rst) begin
            status_nxt   = STATUS_RESET;
            mask_nxt     = MASK_RESET;
            lane_nxt     = LANE_RESET;
            int_stat_nxt = 3'b000;
            int_mask_nxt = 3'b000;
        end
    end

    assign irq_o = |(int_stat_r & int_mask_r);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            aw_held_r  <= 1'b0;
            aw_addr_r  <= 12'h000;
            w_held_r   <= 1'b0;
            w_data_r   <= 32'h0000_0000;
            w_lane0_r  <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= RESP_OKAY;
            rvalid_r   <= 1'b0;
            rresp_r    <= RESP_OKAY;
            rdata_r    <= 32'h0000_0000;
            status_r   <= STATUS_RESET;
            mask_r     <= MASK_RESET;
            lane_r     <= LANE_RESET;
            int_stat_r <= 3'b000;
            int_mask_r <= 3'b000;
            alarm_q_r  <= 1'b0;
        end else begin
            aw_held_r  <= aw_held_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_held_r   <= w_held_nxt;
            w_data_r   <= w_data_nxt;
            w_lane0_r  <= w_lane0_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rresp_r    <= rresp_nxt;
            rdata_r    <= rdata_nxt;
            status_r   <= status_nxt;
            mask_r     <= mask_nxt;
            lane_r     <= lane_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            alarm_q_r  <= summary;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_lane_sets: assert property (@(posedge clk_i) disable iff (srst_i)
        lane_fault_i[3] |=> lane_r[3])
        else $error("lane fault did not set its flag");
    chk_lane_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_fire && w_lane0_nxt && aw_addr_nxt == ADDR_LANE && wbyte[2] && !lane_fault_i[2] && !soft_rst)
        |=> !lane_r[2])
        else $error("lane flag not cleared by write one");
    chk_agg_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_fire && w_lane0_nxt && aw_addr_nxt == ADDR_STATUS && wbyte[BIT_LANE] && lane_fault_i == 8'h00)
        |=> lane_r == 8'h00)
        else $error("aggregate clear missed lane flags");
    chk_lane_reset: assert property (@(posedge clk_i)
        srst_i |=> lane_r == LANE_RESET && status_r == STATUS_RESET)
        else $error("flags not all ones after reset");
    chk_summary_pll: assert property (@(posedge clk_i) disable iff (srst_i)
        (status_r[BIT_PLL] && !mask_r[BIT_PLL]) |-> summary_alarm_o)
        else $error("unmasked alarm missing from summary");
    chk_mask_lane: assert property (@(posedge clk_i) disable iff (srst_i)
        (mask_r[5:2] == 4'hf && mask_r[0] && !status_r[BIT_DIVIDER]) |-> !summary_alarm_o || status_r[7:6] != 2'b00)
        else $error("masked alarm reached summary");
    chk_agg_set: assert property (@(posedge clk_i) disable iff (srst_i)
        (|lane_fault_i) |=> status_r[BIT_LANE])
        else $error("aggregate lane status not set");
    chk_summary_lane: assert property (@(posedge clk_i) disable iff (srst_i)
        (status_r[BIT_LANE] && !mask_r[BIT_LANE]) |-> summary_alarm_o)
        else $error("unmasked lane alarm missing from summary");
    chk_summary_link: assert property (@(posedge clk_i) disable iff (srst_i)
        (status_r[BIT_LINK] && !mask_r[BIT_LINK]) |-> summary_alarm_o)
        else $error("unmasked link alarm missing from summary");
    chk_summary_realign: assert property (@(posedge clk_i) disable iff (srst_i)
        (status_r[BIT_REALIGN] && !mask_r[BIT_REALIGN]) |-> summary_alarm_o)
        else $error("unmasked realign alarm missing from summary");
    chk_summary_divider: assert property (@(posedge clk_i) disable iff (srst_i)
        (status_r[BIT_DIVIDER] && !mask_r[BIT_DIVIDER]) |-> summary_alarm_o)
        else $error("unmasked divider alarm missing from summary");
    chk_mask_all: assert property (@(posedge clk_i) disable iff (srst_i)
        (mask_r[BIT_LANE] && mask_r[BIT_PLL] && mask_r[BIT_LINK] && mask_r[BIT_REALIGN] && mask_r[BIT_DIVIDER])
        |-> !summary_alarm_o)
        else $error("fully masked alarms reached summary");
    chk_mask_write: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_fire && w_lane0_nxt && aw_addr_nxt == ADDR_MASK) |=> mask_r == $past(wbyte))
        else $error("mask write did not land");
    chk_status_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_fire && w_lane0_nxt && aw_addr_nxt == ADDR_STATUS && wbyte[BIT_LANE] && lane_fault_i == 8'h00)
        |=> !status_r[BIT_LANE])
        else $error("aggregate lane status not cleared");
    chk_status_sets: assert property (@(posedge clk_i) disable iff (srst_i)
        pll_unlocked_i |=> status_r[BIT_PLL])
        else $error("pll status not set");
    chk_status_spare: assert property (@(posedge clk_i) disable iff (srst_i)
        status_r[7:6] == 2'b00)
        else $error("spare status bits set");
    chk_lane_any: assert property (@(posedge clk_i) disable iff (srst_i)
        (|lane_fault_i) |=> (lane_r & $past(lane_fault_i)) == $past(lane_fault_i))
        else $error("lane fault flag missing");
    chk_soft_reset: assert property (@(posedge clk_i) disable iff (srst_i)
        soft_rst |=> status_r == STATUS_RESET && mask_r == MASK_RESET && lane_r == LANE_RESET)
        else $error("soft reset values wrong");
    chk_int_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        (rd_fire && s_axi_araddr == ADDR_INT_STAT && events == 8'h00 && !summary) |=> int_stat_r == 3'b000)
        else $error("interrupt status not cleared by read");

    // ****************************************
    // bus checks
    // ****************************************
    chk_wr_resp: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_fire |=> s_axi_bvalid)
        else $error("write response missing");
    chk_rd_resp: assert property (@(posedge clk_i) disable iff (srst_i)
        rd_fire |=> s_axi_rvalid)
        else $error("read response missing");
    chk_wr_busy: assert property (@(posedge clk_i) disable iff (srst_i)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready during response");
    chk_rd_busy: assert property (@(posedge clk_i) disable iff (srst_i)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read channel ready during response");
endmodule

/* File: tb/amf_alarm_top_test.sv */
// self-checking bench for the alarm mask and lane fault flag block
`timescale 1ns/100ps
module amf_alarm_top_test;
    import amf_pkg::*;
    logic        clk_i   = 1'b0;
    logic        srst_i  = 1'b1;
    logic [4:0]  src     = 5'h00;
    logic [7:0]  lane    = 8'h00;
    logic [11:0] awaddr  = 12'h000;
    logic [11:0] araddr  = 12'h000;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, summ, irq;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, v;
    logic [7:0]  bitv [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
    int          err_total = 0;
    int          tests_run = 0;
    always #12.5 clk_i = ~clk_i;
    amf_alarm_top i_amf_alarm_top (.clk_i(clk_i), .srst_i(srst_i),
        .lane_fault_i(lane | {6'h00, src[0], 1'b0}), .pll_unlocked_i(src[1]), .link_not_ready_i(src[2]),
        .clock_realigned_i(src[3]), .divider_mismatch_i(src[4]), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .summary_alarm_o(summ), .irq_o(irq));
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic end_sim;
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bit ok;
        ok = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clk_i);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                ok = 1'b1;
            end
        end
        if (!ok) begin
            err_total++;
            end_sim;
        end
    endtask
    task automatic rd(input logic [11:0] a);
        bit ok;
        ok = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clk_i);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                v = rdata;
                r = rresp;
                ok = 1'b1;
            end
        end
        if (!ok) begin
            err_total++;
            end_sim;
        end
    endtask
    task automatic fire(input logic [4:0] s, input logic [7:0] l);
        src  <= s;
        lane <= l;
        tick(1);
        src  <= 5'h00;
        lane <= 8'h00;
        tick(2);
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic reset_values;
        rd(ADDR_MASK);
        chk("mask", 8'h3f, v);
        rd(ADDR_LANE);
        chk("lane", 8'hff, v);
        rd(ADDR_STATUS);
        chk("status", 8'h3f, v);
        chk("summary", 1'b0, summ);
    endtask
    task automatic lane_flags;
        wr(ADDR_LANE, 8'hff);
        rd(ADDR_LANE);
        chk("lane", 8'h00, v);
        fire(5'h00, 8'h04);
        rd(ADDR_LANE);
        chk("lane", 8'h04, v);
        rd(ADDR_STATUS);
        chk("status lane", 8'h20, v & 8'h20);
        fire(5'h00, 8'h88);
        wr(ADDR_LANE, 8'h04);
        rd(ADDR_LANE);
        chk("lane", 8'h88, v);
        wr(ADDR_STATUS, 8'h20);
        rd(ADDR_LANE);
        chk("lane", 8'h00, v);
        rd(ADDR_STATUS);
        chk("status lane", 8'h00, v & 8'h20);
        lane <= 8'h01;
        wr(ADDR_LANE, 8'h01);
        rd(ADDR_LANE);
        chk("lane", 8'h01, v);
        lane <= 8'h00;
        tick(1);
        wr(ADDR_LANE, 8'h01);
    endtask
    task automatic mask_sources;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_STATUS, 8'h3d);
            wr(ADDR_MASK, 8'h3f);
            fire(5'h01 << i, 8'h00);
            rd(ADDR_STATUS);
            chk("status", bitv[i], v & 8'h3d);
            chk("summary", 1'b0, summ);
            wr(ADDR_MASK, 8'h3f & ~bitv[i]);
            tick(1);
            chk("summary", 1'b1, summ);
            rd(ADDR_SUMMARY);
            chk("summary reg", 8'h01, v);
        end
        wr(ADDR_MASK, 8'h3f);
        wr(ADDR_STATUS, 8'h3d);
    endtask
    task automatic irq_path;
        wr(ADDR_INT_MASK, 8'h00);
        rd(ADDR_INT_STAT);
        fire(5'h02, 8'h00);
        chk("irq", 1'b0, irq);
        wr(ADDR_INT_MASK, 8'h01);
        tick(1);
        chk("irq", 1'b1, irq);
        rd(ADDR_INT_STAT);
        chk("int stat", 8'h01, v & 8'h01);
        tick(1);
        chk("irq", 1'b0, irq);
    endtask
    task automatic bus_errors;
        rd(12'h100);
        chk("rresp", RESP_SLVERR, r);
        chk("rdata", 32'h0000_0000, v);
        wr(12'h100, 8'hff);
        chk("bresp", RESP_SLVERR, r);
        wr(ADDR_SOFT_RST, 8'h01);
        rd(ADDR_LANE);
        chk("lane", 8'hff, v);
        rd(ADDR_STATUS);
        chk("status", 8'h3f, v);
    endtask
    initial begin
        tick(10);
        srst_i <= 1'b0;
        reset_values;
        lane_flags;
        mask_sources;
        irq_path;
        bus_errors;
        end_sim;
    end
endmodule
